/* File: verilog/svd_defs.vh */
/*
 * Constants for the supply-voltage detector and heavy-load protection control.
 * Assumes a 40 MHz pclk and an APB master on the register side.
 */
`ifndef SVD_DEFS_VH
`define SVD_DEFS_VH

// The control word keeps its word index; its byte address is four times that.
`define CTRL_INDEX      12'h076
`define CTRL_OFFSET     12'h1d8
`define STATUS_OFFSET   12'h100
`define MASK_OFFSET     12'h104
`define CONFIG_OFFSET   12'h108

`define MODE_BIT        3
`define ENABLE_BIT      2
`define CTRL_RESET      4'h0

`define EVT_LOW         0
`define EVT_ENTER       1
`define EVT_EXIT        2
`define EVT_WIDTH       3

`define CLK_HZ          40000000
`define INSTR_CYCLE_NS  153000
`define INSTR_CYCLES    ((`INSTR_CYCLE_NS * 40) / 1000)
`define SETTLE_US       100
`define SETTLE_CYCLES   ((`SETTLE_US * 40))

`endif

/* File: verilog/pin_sync.v */
/*
 * Three-flop synchroniser for one pin; output changes once stages two
 * and three agree. Assumes pclk domain on the output side.
 */
`timescale 1ns/1ps
module pin_sync (
    // Clock and reset
    input  wire pclk,
    input  wire presetn,
    // Pin and clean level
    input  wire pin,
    output reg  level
);
    reg s1;
    reg s2;
    reg s3;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1    <= 1'b0;
            s2    <= 1'b0;
            s3    <= 1'b0;
            level <= 1'b0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule // pin_sync

/* File: verilog/svd_ctrl.v */
/*
 * Supply-voltage detector and heavy-load protection controller with an
 * APB register slave. Assumes the comparator output and the 2 Hz timer
 * tick arrive as asynchronous pins, and that variant is a static strap.
 */
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "svd_defs.vh"
module svd_ctrl (
    // APB
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Analog detector side
    input  wire        comparator_low,
    input  wire        tick_2hz_pin,
    input  wire        low_voltage_variant,
    output reg         detector_power,
    output reg         detector_sample,
    output reg         protection_active,
    output reg         display_high_stability,
    // Interrupt
    output wire        irq
);
    reg                   heavy_load_mode_bit;
    reg                   voltage_detect_enable;
    reg                   low_voltage_result;
    reg  [`EVT_WIDTH-1:0] status;
    reg  [`EVT_WIDTH-1:0] mask;
    reg  [15:0]           window_cnt;
    reg                   tick_level_d;
    reg                   variant_low;
    wire                  tick_level;
    wire                  cmp_level;
    wire                  tick_pulse;
    wire                  wr;
    wire                  rd;
    wire                  next_protection;
    wire [`EVT_WIDTH-1:0] events;
    wire [31:0]           window_load;

    pin_sync u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (tick_2hz_pin),
        .level   (tick_level)
    );

    pin_sync u_cmp (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (comparator_low),
        .level   (cmp_level)
    );

    function is_addr;
        input [11:0] a;
        input [11:0] b;
        begin
            is_addr = (a[11:2] == b[11:2]);
        end
    endfunction

    assign pready  = 1'b1;
    assign wr      = psel & penable & pwrite;
    assign rd      = psel & penable & ~pwrite;
    assign pslverr = psel & penable & ~(is_addr(paddr, `CTRL_OFFSET)
                     | is_addr(paddr, `STATUS_OFFSET) | is_addr(paddr, `MASK_OFFSET)
                     | is_addr(paddr, `CONFIG_OFFSET));
    assign tick_pulse = tick_level & ~tick_level_d;

    // Protection turns on by software, or by a low result on the low variant.
    assign next_protection = heavy_load_mode_bit
                             | (variant_low & low_voltage_result);

    assign events = {protection_active & ~next_protection,
                     ~protection_active & next_protection,
                     detector_sample & cmp_level};
    assign irq = |(status & mask);
    assign window_load = `INSTR_CYCLES;

    // Variant strap is captured after reset release.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            variant_low  <= 1'b0;
            tick_level_d <= 1'b0;
        end else begin
            variant_low  <= low_voltage_variant;
            tick_level_d <= tick_level;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            heavy_load_mode_bit   <= 1'b0;
            voltage_detect_enable <= 1'b0;
            mask                  <= {`EVT_WIDTH{1'b0}};
        end else if (wr && is_addr(paddr, `CTRL_OFFSET)) begin
            heavy_load_mode_bit   <= pwdata[`MODE_BIT];
            // Enable cannot survive a write that clears the mode bit.
            voltage_detect_enable <= pwdata[`ENABLE_BIT] & pwdata[`MODE_BIT];
        end else if (wr && is_addr(paddr, `MASK_OFFSET)) begin
            mask <= pwdata[`EVT_WIDTH-1:0];
        end else if (!heavy_load_mode_bit) begin
            voltage_detect_enable <= 1'b0;
        end
    end

    // Sampling window: one instruction cycle at turn-on, then every tick.
    // The window is cut when protection ends, so the detector goes off with it.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            protection_active      <= 1'b0;
            display_high_stability <= 1'b0;
            window_cnt             <= 16'h0000;
            detector_sample        <= 1'b0;
            detector_power         <= 1'b0;
            low_voltage_result     <= 1'b0;
        end else begin
            protection_active      <= next_protection;
            display_high_stability <= next_protection & ~variant_low;
            if (!next_protection) begin
                window_cnt <= 16'h0000;
            end else if (!protection_active) begin
                window_cnt <= window_load[15:0];
            end else if (tick_pulse) begin
                window_cnt <= window_load[15:0];
            end else if (window_cnt != 16'h0000) begin
                window_cnt <= window_cnt - 16'h0001;
            end
            detector_sample <= (window_cnt == 16'h0001);
            detector_power  <= (window_cnt != 16'h0000) | voltage_detect_enable;
            if (window_cnt == 16'h0001 || voltage_detect_enable) begin
                low_voltage_result <= cmp_level;
            end
        end
    end

    // Status bits are sticky; a read clears only the bits it reported, and a
    // new event wins, so nothing set after the setup cycle is lost.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= {`EVT_WIDTH{1'b0}};
        end else if (rd && is_addr(paddr, `STATUS_OFFSET)) begin
            status <= (status & ~prdata[`EVT_WIDTH-1:0]) | events;
        end else begin
            status <= status | events;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            if (is_addr(paddr, `CTRL_OFFSET)) begin
                prdata <= {28'h0000000, heavy_load_mode_bit, low_voltage_result, 2'b00};
            end else if (is_addr(paddr, `STATUS_OFFSET)) begin
                prdata <= {29'h0000000, status};
            end else if (is_addr(paddr, `MASK_OFFSET)) begin
                prdata <= {29'h0000000, mask};
            end else if (is_addr(paddr, `CONFIG_OFFSET)) begin
                prdata <= {30'h0000000, protection_active, variant_low};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end
endmodule // svd_ctrl

/* File: test/svd_ctrl_asserts.sv */
/* Port checker for svd_ctrl.
   Assumes the standard APB timing with zero wait states. */
`timescale 1ns/1ps
module svd_ctrl_asserts (
    // APB
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pslverr,
    // Detector side
    input wire        low_voltage_variant,
    input wire        detector_power,
    input wire        detector_sample,
    input wire        protection_active,
    input wire        display_high_stability
);
    wire [9:0] word = paddr[11:2];
    wire acc  = psel && penable;
    wire map  = word == 10'h076 || word == 10'h040 || word == 10'h041 || word == 10'h042;
    wire wctl = acc && pwrite && word == 10'h076;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_err_unmapped: assert property (acc && !map |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    a_err_mapped: assert property (acc && map |-> !pslverr)
        else $error("mapped access refused");
    a_mode_enter: assert property (wctl && pwdata[3] |-> ##[1:4] protection_active)
        else $error("mode write did not enter protection");
    a_mode_clear: assert property (wctl && !pwdata[3] && !low_voltage_variant
        |-> ##[1:4] !protection_active)
        else $error("mode clear did not leave protection");
    a_enable_clear: assert property (wctl && !pwdata[3] && !low_voltage_variant
        |-> ##[1:4] !detector_power)
        else $error("detector left on after mode clear");
    a_stab_std: assert property ($rose(display_high_stability) |-> !low_voltage_variant && protection_active)
        else $error("display stability set outside standard protection");
    a_sample_pulse: assert property (detector_sample |=> !detector_sample)
        else $error("sample pulse longer than one cycle");
    a_power_on: assert property ($rose(protection_active) |-> ##[0:4] detector_power)
        else $error("detector not powered at turn-on");
endmodule // svd_ctrl_asserts
bind svd_ctrl svd_ctrl_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pslverr(pslverr), .low_voltage_variant(low_voltage_variant),
    .detector_power(detector_power), .detector_sample(detector_sample),
    .protection_active(protection_active), .display_high_stability(display_high_stability));

/* File: test/testbench.sv */
/* Self-checking bench for svd_ctrl.
   Assumes a 40 MHz pclk and zero-wait APB answers. */
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module testbench;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        comparator_low = 0, tick_2hz_pin = 0, low_voltage_variant = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rnd, exp_word, q[$];
    wire  [31:0] prdata;
    wire         pready, pslverr, detector_power, detector_sample;
    wire         protection_active, display_high_stability, irq;
    int          n_errors = 0, n_compared = 0;
    svd_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .comparator_low(comparator_low), .tick_2hz_pin(tick_2hz_pin),
        .low_voltage_variant(low_voltage_variant), .detector_power(detector_power),
        .detector_sample(detector_sample), .protection_active(protection_active),
        .display_high_stability(display_high_stability), .irq(irq));
    initial forever #12.5 pclk = ~pclk;
    task automatic bus(input logic w, input [11:0] a, input [31:0] d);
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (!pready);
        psel <= 0; penable <= 0;
    endtask
    task automatic rd(input [11:0] a, input [31:0] e);
        q.push_back(e);
        bus(0, a, 0);
    endtask
    task automatic ws(input int n);
        for (int i = 0; i < n && detector_sample !== 1'b1; i++) @(negedge pclk);
        `CHK(detector_sample, 1'b1)
    endtask
    task automatic tick();
        @(posedge pclk) tick_2hz_pin <= 1;
        repeat (8) @(posedge pclk);
        tick_2hz_pin <= 0;
        ws(6300);
    endtask
    task automatic final_report();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Read results are compared against the oldest expectation noted.
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && q.size() > 0) begin
            exp_word = q.pop_front();
            `CHK(prdata, exp_word)
        end
    end
    initial begin
        repeat (40000) @(posedge pclk);
        n_errors++;
        final_report();
    end
    initial begin
        void'($urandom(32'hc48c1484));
        rnd = $urandom;
        repeat (16) @(posedge pclk);
        presetn <= 1;
        rd(12'h1d8, 32'h0);
        rd(12'h200, 32'h0);
        bus(1, 12'h104, 32'h7);
        bus(1, 12'h1d8, {rnd[31:4], 4'h8});
        ws(6300);
        @(negedge pclk);
        `CHK(protection_active, 1'b1)
        `CHK(display_high_stability, 1'b1)
        `CHK(irq, 1'b1)
        rd(12'h100, 32'h2);
        tick();
        bus(1, 12'h1d8, 32'h4);
        rd(12'h1d8, 32'h0);
        @(posedge pclk) comparator_low <= 1;
        bus(1, 12'h1d8, 32'hc);
        repeat (4000) @(posedge pclk);
        rd(12'h1d8, 32'hc);
        bus(1, 12'h1d8, 32'h0);
        rd(12'h1d8, 32'h4);
        @(negedge pclk) `CHK(protection_active, 1'b0)
        `CHK(detector_power, 1'b0)
        @(posedge pclk) comparator_low <= 0;
        bus(1, 12'h1d8, 32'hc);
        repeat (4000) @(posedge pclk);
        bus(1, 12'h1d8, 32'h0);
        rd(12'h1d8, 32'h0);
        @(posedge pclk) low_voltage_variant <= 1;
        comparator_low <= 1;
        bus(1, 12'h1d8, 32'hc);
        repeat (4000) @(negedge pclk);
        `CHK(protection_active, 1'b1)
        `CHK(display_high_stability, 1'b0)
        bus(1, 12'h1d8, 32'h0);
        repeat (5) @(negedge pclk);
        `CHK(protection_active, 1'b1)
        @(posedge pclk) comparator_low <= 0;
        tick();
        repeat (8) @(negedge pclk);
        `CHK(protection_active, 1'b0)
        final_report();
    end
endmodule // testbench
